// >>> shared/lmix_pkg.sv
// Purpose: Shared constants and types for the literal/move/indirect exec block
// Assumes: One core clock, synchronous active-high reset
// Notes:   Opcode values and register offsets are local to this block
package lmix_pkg;
    // ****************************************
    // Widths
    // ****************************************
    localparam int LMIX_PTR_W = 16;
    localparam int LMIX_RAM_AW = 12;
    localparam int LMIX_DW = 8;
    localparam int LMIX_BUS_AW = 12;
    localparam int LMIX_BANK_W = 5;
    localparam int LMIX_PCH_W = 7;
    localparam int LMIX_FILE_W = 7;
    localparam int LMIX_OFF_W = 6;

    // ****************************************
    // Register map (plain port)
    // ****************************************
    localparam logic [3:0] LMIX_REG_ACC = 4'h0;
    localparam logic [3:0] LMIX_REG_BANK = 4'h1;
    localparam logic [3:0] LMIX_REG_PCH = 4'h2;
    localparam logic [3:0] LMIX_REG_PRESC = 4'h3;
    localparam logic [3:0] LMIX_REG_P0_LO = 4'h4;
    localparam logic [3:0] LMIX_REG_P0_HI = 4'h5;
    localparam logic [3:0] LMIX_REG_P1_LO = 4'h6;
    localparam logic [3:0] LMIX_REG_P1_HI = 4'h7;
    localparam logic [3:0] LMIX_REG_PWR = 4'h8;
    localparam logic [3:0] LMIX_REG_STAT = 4'h9;
    localparam int LMIX_RAM_SEL_BIT = 11;
    localparam int LMIX_PWR_SWR_BIT = 0;
    localparam logic [6:0] LMIX_INDF0_ADDR = 7'h00;
    localparam logic [6:0] LMIX_INDF1_ADDR = 7'h01;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] LMIX_ACC_RST = 8'h00;
    localparam logic [4:0] LMIX_BANK_RST = 5'h00;
    localparam logic [6:0] LMIX_PCH_RST = 7'h00;
    localparam logic [7:0] LMIX_PRESC_RST = 8'hff;
    localparam logic [15:0] LMIX_PTR_RST = 16'h0000;
    localparam logic [7:0] LMIX_STAT_RST = 8'h00;

    // ****************************************
    // Instruction carrier
    // ****************************************
    typedef enum logic [3:0] {
        LMIX_OP_NOP = 4'h0,
        LMIX_OP_LD_BANK = 4'h1,
        LMIX_OP_LD_PCH = 4'h2,
        LMIX_OP_LD_ACC = 4'h3,
        LMIX_OP_ST_FILE = 4'h4,
        LMIX_OP_ST_IND = 4'h5,
        LMIX_OP_LD_CFG = 4'h6,
        LMIX_OP_SW_RESET = 4'h7
    } lmix_op_t;

    // Pointer modes: 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
    typedef struct packed {
        lmix_op_t op;
        logic [7:0] lit;
        logic [6:0] faddr;
        logic psel;
        logic rel;
        logic [1:0] mode;
        logic [5:0] offset;
    } lmix_instr_t;
endpackage

// >>> hw/lmix_ptr_unit.sv
// Purpose: One indirect pointer with pre/post step and relative offset
// Assumes: Instruction update wins over a software byte write
// Notes:   Arithmetic is modulo 2^16, so the pointer wraps both ways
module lmix_ptr_unit
    import lmix_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_wr_lo,
    input wire logic i_wr_hi,
    input wire logic [7:0] i_wdata,
    input wire logic i_use,
    input wire logic i_rel,
    input wire logic [1:0] i_mode,
    input wire logic [5:0] i_offset,
    output logic [15:0] o_ptr,
    output logic [15:0] o_ea
);
    logic [15:0] ptr_r;
    logic [15:0] ptr_nxt;
    logic [15:0] step;
    logic [15:0] off_ext;

    // Step and effective address; mode bit 0 picks decrement
    always_comb begin
        step = i_mode[0] ? 16'hffff : 16'h0001;
        off_ext = {{10{i_offset[5]}}, i_offset};
        if (i_rel) begin
            o_ea = ptr_r + off_ext;
        end else if (!i_mode[1]) begin
            o_ea = ptr_r + step;
        end else begin
            o_ea = ptr_r;
        end
        ptr_nxt = ptr_r;
        if (i_wr_lo) begin
            ptr_nxt[7:0] = i_wdata;
        end
        if (i_wr_hi) begin
            ptr_nxt[15:8] = i_wdata;
        end
        if (i_use && !i_rel) begin
            ptr_nxt = ptr_r + step;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ptr_r <= LMIX_PTR_RST;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    assign o_ptr = ptr_r;
endmodule

// >>> hw/lmix_file_ram.sv
// Purpose: File register storage reached directly and through pointers
// Assumes: Asynchronous read, single write port
// Notes:   Contents survive both resets, as data memory does
module lmix_file_ram #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input wire logic i_core_clk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Write port; no reset so the array maps onto plain memory
    always_ff @(posedge i_core_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    assign o_rdata = mem[i_raddr];
endmodule

// >>> hw/lmix_exec.sv
// Purpose: Executes literal loads, accumulator stores, indirect stores,
//          no-op and software reset for the 8-bit core
// Assumes: One instruction per valid cycle; register port on same clock
// Notes:   Instruction writes win over register-port writes in one cycle
module lmix_exec
    import lmix_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_instr_vld,
    input wire lmix_instr_t i_instr,
    input wire logic [LMIX_BUS_AW-1:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    output logic [7:0] o_rd_data,
    output logic [7:0] o_acc,
    output logic [4:0] o_bank,
    output logic [6:0] o_pch,
    output logic [7:0] o_prescale,
    output logic o_sw_reset_flag_n,
    output logic o_dev_reset
);
    // ****************************************
    // Declarations
    // ****************************************
    logic soft_rst_r;
    logic soft_rst_nxt;
    logic rst_all;
    logic exec;
    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    logic [4:0] bank_r;
    logic [4:0] bank_nxt;
    logic [6:0] pch_r;
    logic [6:0] pch_nxt;
    logic [7:0] presc_r;
    logic [7:0] presc_nxt;
    logic [7:0] stat_r;
    logic [7:0] stat_nxt;
    logic swr_flag_n_r;
    logic swr_flag_n_nxt;
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;
    logic reg_wr;
    logic ram_bus_sel;
    logic [3:0] reg_idx;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [15:0] ea0;
    logic [15:0] ea1;
    logic use0;
    logic use1;
    logic is_ind;
    logic is_indf;
    logic ram_we;
    logic [LMIX_RAM_AW-1:0] ram_waddr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_rdata;

    // ****************************************
    // Reset and decode
    // ****************************************
    // A software reset is one internal cycle that resets the core registers and both pointers like i_srst
    assign rst_all = i_srst | soft_rst_r;
    // Instructions arriving during that cycle are dropped
    assign exec = i_instr_vld & ~soft_rst_r;
    assign ram_bus_sel = i_addr[LMIX_RAM_SEL_BIT];
    assign reg_idx = i_addr[3:0];
    assign reg_wr = i_wr_stb & ~ram_bus_sel;
    assign is_ind = exec && (i_instr.op == LMIX_OP_ST_IND);
    assign is_indf = (i_instr.faddr == LMIX_INDF0_ADDR)
        || (i_instr.faddr == LMIX_INDF1_ADDR);
    // Pointer steps only on indirect stores, never through status
    assign use0 = is_ind && !i_instr.psel;
    assign use1 = is_ind && i_instr.psel;

    // ****************************************
    // Pointers
    // ****************************************
    // Same unit twice; each steps on its own select
    lmix_ptr_unit u_ptr0 (
        .i_core_clk(i_core_clk),
        .i_srst(rst_all),
        .i_wr_lo(reg_wr && reg_idx == LMIX_REG_P0_LO),
        .i_wr_hi(reg_wr && reg_idx == LMIX_REG_P0_HI),
        .i_wdata(i_wr_data),
        .i_use(use0),
        .i_rel(i_instr.rel),
        .i_mode(i_instr.mode),
        .i_offset(i_instr.offset),
        .o_ptr(ptr0),
        .o_ea(ea0)
    );

    lmix_ptr_unit u_ptr1 (
        .i_core_clk(i_core_clk),
        .i_srst(rst_all),
        .i_wr_lo(reg_wr && reg_idx == LMIX_REG_P1_LO),
        .i_wr_hi(reg_wr && reg_idx == LMIX_REG_P1_HI),
        .i_wdata(i_wr_data),
        .i_use(use1),
        .i_rel(i_instr.rel),
        .i_mode(i_instr.mode),
        .i_offset(i_instr.offset),
        .o_ptr(ptr1),
        .o_ea(ea1)
    );

    // ****************************************
    // File store path
    // ****************************************
    // Direct, redirected and indirect stores share one write port;
    // the pointer address is cut to the memory size, so high bits alias
    always_comb begin
        ram_we = 1'b0;
        ram_waddr = i_addr[LMIX_RAM_AW-1:0];
        ram_wdata = i_wr_data;
        if (exec && i_instr.op == LMIX_OP_ST_FILE) begin
            ram_we = 1'b1;
            ram_wdata = acc_r;
            if (is_indf) begin
                ram_waddr = (i_instr.faddr == LMIX_INDF0_ADDR)
                    ? ptr0[LMIX_RAM_AW-1:0] : ptr1[LMIX_RAM_AW-1:0];
            end else begin
                ram_waddr = {bank_r, i_instr.faddr};
            end
        end else if (is_ind) begin
            ram_we = 1'b1;
            ram_wdata = acc_r;
            ram_waddr = i_instr.psel ? ea1[LMIX_RAM_AW-1:0]
                : ea0[LMIX_RAM_AW-1:0];
        end else if (i_wr_stb && ram_bus_sel) begin
            ram_we = 1'b1;
        end
    end

    lmix_file_ram #(
        .AW(LMIX_RAM_AW),
        .DW(LMIX_DW)
    ) u_ram (
        .i_core_clk(i_core_clk),
        .i_we(ram_we),
        .i_waddr(ram_waddr),
        .i_wdata(ram_wdata),
        .i_raddr(i_addr[LMIX_RAM_AW-1:0]),
        .o_rdata(ram_rdata)
    );

    // ****************************************
    // Core registers
    // ****************************************
    // Port writes first, instruction effects override them
    always_comb begin
        acc_nxt = acc_r;
        bank_nxt = bank_r;
        pch_nxt = pch_r;
        presc_nxt = presc_r;
        stat_nxt = stat_r;
        soft_rst_nxt = 1'b0;
        if (reg_wr) begin
            unique case (reg_idx)
                LMIX_REG_ACC: acc_nxt = i_wr_data;
                LMIX_REG_BANK: bank_nxt = i_wr_data[4:0];
                LMIX_REG_PCH: pch_nxt = i_wr_data[6:0];
                LMIX_REG_PRESC: presc_nxt = i_wr_data;
                LMIX_REG_STAT: stat_nxt = i_wr_data;
                default: ;
            endcase
        end
        if (exec) begin
            unique case (i_instr.op)
                LMIX_OP_NOP: ;
                LMIX_OP_LD_BANK: bank_nxt = i_instr.lit[4:0];
                LMIX_OP_LD_PCH: pch_nxt = i_instr.lit[6:0];
                LMIX_OP_LD_ACC: acc_nxt = i_instr.lit;
                LMIX_OP_ST_FILE: ;
                LMIX_OP_ST_IND: ;
                LMIX_OP_LD_CFG: presc_nxt = acc_r;
                LMIX_OP_SW_RESET: soft_rst_nxt = 1'b1;
                default: ; // Codes outside this subset do nothing here
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            acc_r <= LMIX_ACC_RST;
            bank_r <= LMIX_BANK_RST;
            pch_r <= LMIX_PCH_RST;
            presc_r <= LMIX_PRESC_RST;
            stat_r <= LMIX_STAT_RST;
        end else begin
            acc_r <= acc_nxt;
            bank_r <= bank_nxt;
            pch_r <= pch_nxt;
            presc_r <= presc_nxt;
            stat_r <= stat_nxt;
        end
    end

    // Pulse clears itself one cycle later; the external reset also clears it
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= soft_rst_nxt;
        end
    end

    // ****************************************
    // Reset-cause flag
    // ****************************************
    // Must outlive the internal reset, so only i_srst resets it;
    // the instruction clear wins over a port write of one
    always_comb begin
        swr_flag_n_nxt = swr_flag_n_r;
        if (reg_wr && reg_idx == LMIX_REG_PWR
            && i_wr_data[LMIX_PWR_SWR_BIT]) begin
            swr_flag_n_nxt = 1'b1;
        end
        if (exec && i_instr.op == LMIX_OP_SW_RESET) begin
            swr_flag_n_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            swr_flag_n_r <= 1'b1;
        end else begin
            swr_flag_n_r <= swr_flag_n_nxt;
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    // Data stand only in the cycle after the strobe
    always_comb begin
        rd_data_nxt = 8'h00;
        if (i_rd_stb && ram_bus_sel) begin
            rd_data_nxt = ram_rdata;
        end else if (i_rd_stb) begin
            unique case (reg_idx)
                LMIX_REG_ACC: rd_data_nxt = acc_r;
                LMIX_REG_BANK: rd_data_nxt = {3'h0, bank_r};
                LMIX_REG_PCH: rd_data_nxt = {1'h0, pch_r};
                LMIX_REG_PRESC: rd_data_nxt = presc_r;
                LMIX_REG_P0_LO: rd_data_nxt = ptr0[7:0];
                LMIX_REG_P0_HI: rd_data_nxt = ptr0[15:8];
                LMIX_REG_P1_LO: rd_data_nxt = ptr1[7:0];
                LMIX_REG_P1_HI: rd_data_nxt = ptr1[15:8];
                LMIX_REG_PWR: rd_data_nxt = {7'h00, swr_flag_n_r};
                LMIX_REG_STAT: rd_data_nxt = stat_r;
                default: rd_data_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign o_rd_data = rd_data_r;
    assign o_acc = acc_r;
    assign o_bank = bank_r;
    assign o_pch = pch_r;
    assign o_prescale = presc_r;
    assign o_sw_reset_flag_n = swr_flag_n_r;
    assign o_dev_reset = soft_rst_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    chk_bank_load: assert property (
        exec && i_instr.op == LMIX_OP_LD_BANK
        |=> bank_r == $past(i_instr.lit[4:0]))
        else $error("bank select not loaded");

    chk_pch_load: assert property (
        exec && i_instr.op == LMIX_OP_LD_PCH
        |=> pch_r == $past(i_instr.lit[6:0]) && $stable(stat_r))
        else $error("pc high latch not loaded");

    chk_acc_load: assert property (
        exec && i_instr.op == LMIX_OP_LD_ACC
        |=> o_acc == $past(i_instr.lit))
        else $error("accumulator not loaded");

    chk_file_store: assert property (
        exec && i_instr.op == LMIX_OP_ST_FILE && !is_indf
        |-> ram_we && ram_waddr == {bank_r, i_instr.faddr}
        && ram_wdata == acc_r)
        else $error("direct store wrong");

    chk_rel_addr: assert property (
        use0 && i_instr.rel
        |-> ram_waddr == 12'(ptr0 + {{10{i_instr.offset[5]}}, i_instr.offset})
        ##1 $stable(ptr0))
        else $error("relative store wrong");

    chk_pre_inc: assert property (
        use0 && !i_instr.rel && i_instr.mode == 2'b00
        |-> ram_waddr == 12'(ptr0 + 16'h0001)
        ##1 ptr0 == 16'($past(ptr0) + 16'h0001))
        else $error("pre-increment wrong");

    chk_post_dec: assert property (
        use1 && !i_instr.rel && i_instr.mode == 2'b11
        |-> ram_waddr == ptr1[LMIX_RAM_AW-1:0]
        ##1 ptr1 == 16'($past(ptr1) - 16'h0001))
        else $error("post-decrement wrong");

    chk_ptr_wrap: assert property (
        use0 && !i_instr.rel && !i_instr.mode[0] && ptr0 == 16'hffff
        |=> ptr0 == 16'h0000)
        else $error("pointer did not wrap");

    chk_indf_redirect: assert property (
        exec && i_instr.op == LMIX_OP_ST_FILE
        && i_instr.faddr == LMIX_INDF1_ADDR
        |-> ram_we && ram_waddr == ptr1[LMIX_RAM_AW-1:0])
        else $error("indirect port not redirected");

    chk_flags_kept: assert property (
        exec && !(reg_wr && reg_idx == LMIX_REG_STAT) |=> $stable(stat_r))
        else $error("status changed by instruction");

    chk_cfg_load: assert property (
        exec && i_instr.op == LMIX_OP_LD_CFG
        |=> o_prescale == $past(acc_r))
        else $error("prescaler config not loaded");

    chk_sw_reset: assert property (
        exec && i_instr.op == LMIX_OP_SW_RESET
        |=> o_dev_reset && !o_sw_reset_flag_n
        ##1 !o_dev_reset && acc_r == LMIX_ACC_RST
        && ptr0 == LMIX_PTR_RST && presc_r == LMIX_PRESC_RST)
        else $error("software reset incomplete");

    chk_nop_idle: assert property (
        exec && i_instr.op == LMIX_OP_NOP && !i_wr_stb
        |-> !ram_we ##1 $stable(acc_r) && $stable(bank_r)
        && $stable(ptr0) && $stable(ptr1) && $stable(presc_r))
        else $error("no-op changed state");
endmodule

// >>> verification/lmix_exec_tb.sv
// Purpose: Self-checking bench for the literal/move/indirect exec block
// Assumes: Port reads return data one cycle after the strobe
// Notes:   File storage is only visible through the port at 800h and above
module tb
    import lmix_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_core_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_instr_vld = 1'b0;
    lmix_instr_t i_instr = '0;
    logic [11:0] i_addr = 12'h000;
    logic [7:0] i_wr_data = 8'h00;
    logic i_wr_stb = 1'b0;
    logic i_rd_stb = 1'b0;
    logic [7:0] o_rd_data, o_acc, o_prescale;
    logic [4:0] o_bank;
    logic [6:0] o_pch;
    logic o_sw_reset_flag_n, o_dev_reset;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;

    lmix_exec dut_u (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_instr_vld(i_instr_vld),
        .i_instr(i_instr), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb),
        .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .o_acc(o_acc), .o_bank(o_bank),
        .o_pch(o_pch), .o_prescale(o_prescale), .o_sw_reset_flag_n(o_sw_reset_flag_n),
        .o_dev_reset(o_dev_reset));

    // ****************************************
    // Clock, timeout and shared tasks
    // ****************************************
    initial begin
        forever #5 i_core_clk = ~i_core_clk;
    end

    // Generous ceiling; the whole run needs well under a thousand cycles
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic lmix_instr_t mk(input lmix_op_t op, input logic [7:0] lit,
        input logic [6:0] fa, input logic ps, input logic rl, input logic [1:0] md,
        input logic [5:0] off);
        lmix_instr_t t;
        t = '{op: op, lit: lit, faddr: fa, psel: ps, rel: rl, mode: md, offset: off};
        return t;
    endfunction

    // Each access ends with an idle cycle so no strobe is driven twice in one step
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wr_data <= d;
        i_wr_stb <= 1'b1;
        @(posedge i_core_clk);
        i_wr_stb <= 1'b0;
        @(posedge i_core_clk);
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        i_addr <= a;
        i_rd_stb <= 1'b1;
        @(posedge i_core_clk);
        i_rd_stb <= 1'b0;
        #1 d = o_rd_data;
        @(posedge i_core_clk);
    endtask

    task automatic exe(input lmix_instr_t t);
        i_instr <= t;
        i_instr_vld <= 1'b1;
        @(posedge i_core_clk);
        i_instr_vld <= 1'b0;
        @(posedge i_core_clk);
    endtask

    task automatic setp(input logic ps, input logic [15:0] v);
        wr({8'h00, ps ? LMIX_REG_P1_LO : LMIX_REG_P0_LO}, v[7:0]);
        wr({8'h00, ps ? LMIX_REG_P1_HI : LMIX_REG_P0_HI}, v[15:8]);
    endtask

    task automatic getp(input logic ps, output logic [15:0] v);
        rd({8'h00, ps ? LMIX_REG_P1_LO : LMIX_REG_P0_LO}, v[7:0]);
        rd({8'h00, ps ? LMIX_REG_P1_HI : LMIX_REG_P0_HI}, v[15:8]);
    endtask

    task automatic ldacc(input logic [7:0] v);
        exe(mk(LMIX_OP_LD_ACC, v, 7'h00, 1'b0, 1'b0, 2'b00, 6'h00));
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_lit();
        logic [7:0] d;
        exe(mk(LMIX_OP_LD_BANK, 8'h1f, 7'h00, 1'b0, 1'b0, 2'b00, 6'h00));
        chk("bank", o_bank, 5'h1f);
        exe(mk(LMIX_OP_LD_PCH, 8'h7f, 7'h00, 1'b0, 1'b0, 2'b00, 6'h00));
        chk("pch", o_pch, 7'h7f);
        // Literal load then config load back to back: each lands after a single edge
        i_instr <= mk(LMIX_OP_LD_ACC, 8'hff, 7'h00, 1'b0, 1'b0, 2'b00, 6'h00);
        i_instr_vld <= 1'b1;
        @(posedge i_core_clk);
        i_instr <= mk(LMIX_OP_LD_CFG, 8'h00, 7'h00, 1'b0, 1'b0, 2'b00, 6'h00);
        #1 chk("acc", o_acc, 8'hff);
        @(posedge i_core_clk);
        i_instr_vld <= 1'b0;
        #1 chk("prescale", o_prescale, 8'hff);
        @(posedge i_core_clk);
        ldacc(8'h5a);
        chk("acc", o_acc, 8'h5a);
        exe(mk(LMIX_OP_LD_CFG, 8'h00, 7'h00, 1'b0, 1'b0, 2'b00, 6'h00));
        chk("prescale", o_prescale, 8'h5a);
        rd({8'h00, LMIX_REG_STAT}, d);
        chk("status", d, 8'h00);
        $display("test literals done");
    endtask

    task automatic t_file();
        logic [7:0] d;
        wr(12'hf80, 8'h11);
        setp(1'b0, 16'h0820);
        ldacc(8'ha5);
        exe(mk(LMIX_OP_ST_FILE, 8'h00, 7'h7f, 1'b0, 1'b0, 2'b00, 6'h00));
        rd(12'hfff, d);
        chk("file fff", d, 8'ha5);
        // Direct store to the indirect port goes through the pointer
        ldacc(8'h3b);
        exe(mk(LMIX_OP_ST_FILE, 8'h00, LMIX_INDF0_ADDR, 1'b0, 1'b0, 2'b00, 6'h00));
        rd(12'h820, d);
        chk("ram 820", d, 8'h3b);
        // The second indirect port follows the other pointer
        setp(1'b1, 16'h0830);
        exe(mk(LMIX_OP_ST_FILE, 8'h00, LMIX_INDF1_ADDR, 1'b0, 1'b0, 2'b00, 6'h00));
        rd(12'h830, d);
        chk("ram 830", d, 8'h3b);
        rd(12'hf80, d);
        chk("ram f80", d, 8'h11);
        $display("test file store done");
    endtask

    task automatic t_ind();
        logic [7:0] d;
        logic [15:0] p;
        logic [11:0] ea;
        logic [5:0] offs [2] = '{6'h20, 6'h1f};
        logic [11:0] eas [2] = '{12'h820, 12'h85f};
        for (int ps = 0; ps < 2; ps++) begin
            for (int m = 0; m < 4; m++) begin
                setp(ps[0], 16'h0810);
                ldacc(8'h40 + 8'(ps * 4 + m));
                exe(mk(LMIX_OP_ST_IND, 8'h00, 7'h00, ps[0], 1'b0, m[1:0], 6'h00));
                ea = (m == 0) ? 12'h811 : (m == 1) ? 12'h80f : 12'h810;
                rd(ea, d);
                chk("ind data", d, 8'h40 + 8'(ps * 4 + m));
                getp(ps[0], p);
                chk("ptr after", p, m[0] ? 16'h080f : 16'h0811);
            end
        end
        // Signed offset at both ends of its range leaves the pointer alone
        for (int k = 0; k < 2; k++) begin
            setp(k[0], 16'h0840);
            ldacc(8'h60 + 8'(k));
            exe(mk(LMIX_OP_ST_IND, 8'h00, 7'h00, k[0], 1'b1, 2'b10, offs[k]));
            rd(eas[k], d);
            chk("rel data", d, 8'h60 + 8'(k));
            getp(k[0], p);
            chk("rel ptr", p, 16'h0840);
        end
        // Wrap both ways
        setp(1'b0, 16'hffff);
        ldacc(8'h77);
        exe(mk(LMIX_OP_ST_IND, 8'h00, 7'h00, 1'b0, 1'b0, 2'b10, 6'h00));
        rd(12'hfff, d);
        chk("wrap data", d, 8'h77);
        getp(1'b0, p);
        chk("wrap up", p, 16'h0000);
        exe(mk(LMIX_OP_ST_IND, 8'h00, 7'h00, 1'b0, 1'b0, 2'b11, 6'h00));
        getp(1'b0, p);
        chk("wrap down", p, 16'hffff);
        rd({8'h00, LMIX_REG_STAT}, d);
        chk("status", d, 8'h00);
        $display("test indirect done");
    endtask

    task automatic t_nop();
        logic [15:0] p;
        ldacc(8'h3c);
        setp(1'b0, 16'h0abc);
        exe(mk(LMIX_OP_NOP, 8'hff, 7'h7f, 1'b0, 1'b0, 2'b00, 6'h1f));
        exe(mk(LMIX_OP_NOP, 8'h00, 7'h00, 1'b0, 1'b0, 2'b10, 6'h00));
        chk("nop acc", o_acc, 8'h3c);
        chk("nop bank", o_bank, 5'h1f);
        chk("nop pch", o_pch, 7'h7f);
        chk("nop presc", o_prescale, 8'h5a);
        getp(1'b0, p);
        chk("nop ptr", p, 16'h0abc);
        $display("test nop done");
    endtask

    task automatic t_swr();
        logic [15:0] p;
        i_instr <= mk(LMIX_OP_SW_RESET, 8'h00, 7'h00, 1'b0, 1'b0, 2'b00, 6'h00);
        i_instr_vld <= 1'b1;
        @(posedge i_core_clk);
        // This load falls in the reset cycle and must be dropped
        i_instr <= mk(LMIX_OP_LD_ACC, 8'h55, 7'h00, 1'b0, 1'b0, 2'b00, 6'h00);
        #1 chk("dev reset", o_dev_reset, 1'b1);
        chk("flag_n", o_sw_reset_flag_n, 1'b0);
        @(posedge i_core_clk);
        i_instr_vld <= 1'b0;
        #1 chk("dev reset end", o_dev_reset, 1'b0);
        chk("rst acc", o_acc, LMIX_ACC_RST);
        chk("rst bank", o_bank, LMIX_BANK_RST);
        chk("rst pch", o_pch, LMIX_PCH_RST);
        chk("rst presc", o_prescale, LMIX_PRESC_RST);
        chk("flag_n kept", o_sw_reset_flag_n, 1'b0);
        @(posedge i_core_clk);
        getp(1'b0, p);
        chk("rst ptr", p, LMIX_PTR_RST);
        wr({8'h00, LMIX_REG_PWR}, 8'h01);
        chk("flag_n set", o_sw_reset_flag_n, 1'b1);
        $display("test software reset done");
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [7:0] d;
        repeat (16) @(posedge i_core_clk);
        i_srst <= 1'b0;
        @(posedge i_core_clk);
        rd({8'h00, LMIX_REG_PRESC}, d);
        chk("presc reset", d, LMIX_PRESC_RST);
        rd({8'h00, LMIX_REG_PWR}, d);
        chk("pwr reset", d[LMIX_PWR_SWR_BIT], 1'b1);
        rd(12'h00a, d);
        chk("unmapped", d, 8'h00);
        t_lit();
        t_file();
        t_ind();
        t_nop();
        t_swr();
        results();
    end
endmodule
